// ===== hdl/sctx_pkg.sv
// package: constants, types and register map of the serial config and tx data port
package sctx_pkg;

    // ------------------------------------------------------------------
    // wishbone register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADR_LATCH0 = 8'h00;
    localparam logic [7:0] ADR_LATCH1 = 8'h04;
    localparam logic [7:0] ADR_LATCH2 = 8'h08;
    localparam logic [7:0] ADR_LATCH3 = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;
    localparam logic [7:0] ADR_MASK   = 8'h14;
    localparam logic [7:0] ADR_SHIFT  = 8'h18;
    localparam logic [7:0] ADR_LIVE   = 8'h1C;

    // ------------------------------------------------------------------
    // word layout and latch fields
    // ------------------------------------------------------------------
    localparam int WORD_W     = 32;
    localparam int LAT_REF    = 0;
    localparam int LAT_MOD    = 2;
    localparam int LAT_MUX    = 3;
    localparam int CLKDIV_HI  = 11;
    localparam int CLKDIV_LO  = 8;
    localparam int XOEB_BIT   = 12;
    localparam int MODE_HI    = 5;
    localparam int MODE_LO    = 4;
    localparam int RATE_HI    = 21;
    localparam int RATE_LO    = 6;
    localparam int MUXSEL_HI  = 6;
    localparam int MUXSEL_LO  = 4;

    localparam logic [1:0] MODE_FSK  = 2'h0;
    localparam logic [1:0] MODE_GFSK = 2'h1;
    localparam logic [1:0] MODE_ASK  = 2'h2;
    localparam logic [1:0] MODE_GOOK = 2'h3;

    localparam logic [2:0] MUX_REG_READY = 3'h0;
    localparam logic [2:0] MUX_LOCK      = 3'h1;
    localparam logic [2:0] MUX_BATT_LOW  = 3'h2;
    localparam logic [2:0] MUX_HIGH      = 3'h3;

    // ------------------------------------------------------------------
    // event bits of status and mask
    // ------------------------------------------------------------------
    localparam int EV_LOAD    = 0;
    localparam int EV_OVERRUN = 1;
    localparam int EV_UNLOCK  = 2;
    localparam int EV_TXBIT   = 3;
    localparam int EV_W       = 4;
    localparam logic [5:0] NBITS_FULL = 6'h20;

    typedef enum logic [2:0] {
        TXC_IDLE = 3'b001,
        TXC_LOW  = 3'b010,
        TXC_HIGH = 3'b100
    } sctx_txc_e;

    typedef struct packed {
        logic pll_lock;
        logic batt_low;
        logic reg_ready;
    } sctx_stat_s;

    typedef struct packed {
        logic                          sclk_p;
        logic                          le_p;
        logic                          osc_p;
        logic                          lock_p;
        logic [WORD_W-1:0]             shift;
        logic [5:0]                    nbits;
        logic [3:0][WORD_W-1:0]        latch;
        sctx_txc_e                     txc;
        logic [15:0]                   txc_cnt;
        logic                          tx_clk;
        logic                          tx_bit;
        logic [3:0]                    ref_cnt;
        logic                          clk_out;
        logic                          mux_out;
        logic [EV_W-1:0]               stat;
        logic [EV_W-1:0]               mask;
        logic                          ack;
        logic [WORD_W-1:0]             rdat;
    } sctx_state_s;

endpackage

// ===== hdl/sctx_port.sv
// serial configuration port, tx bit path, status mux and clock out of the transmitter
//
// Overview of operation
// [RULE1] each serial clock rising edge shifts the data input into a 32-bit register
// [RULE2] host sends words msb first; the two lowest bits pick the latch
// [RULE3] load strobe rising edge copies the shift register into the selected latch
// [RULE4] tx bit clock runs only in gaussian modes, at the configured data rate
// [RULE5] host changes tx data only on falling edges of the tx bit clock
// [RULE6] tx data is sampled on tx bit clock rising edges, mid bit
// [RULE7] the bit stream to modulate enters on the tx bit input
// [RULE8] clock out is a divided reference copy with equal high and low times
// [RULE9] status mux can show pll lock or battery monitor result
// [RULE10] status mux can also show the regulator ready indication
// [RULE11] with an external reference the oscillator disable bit powers the crystal down
// [RULE12] chip enable low clears all latches; host rewrites them afterwards
// [RULE13] beyond thirty-two edges only the newest thirty-two bits are kept
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps

module sctx_port (
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    output wire logic [31:0]         wb_dat_o,
    output wire logic                wb_ack_o,
    input  wire logic                chip_enable,
    input  wire logic                serial_clk,
    input  wire logic                serial_data,
    input  wire logic                latch_load_strobe,
    input  wire logic                tx_bit_input,
    input  wire logic                ref_oscillator_pin_two,
    input  wire sctx_pkg::sctx_stat_s status_in,
    output wire logic                tx_bit_clock,
    output wire logic                modulated_bit,
    output wire logic                status_mux_output,
    output wire logic                divided_ref_clock_out,
    output wire logic                xtal_osc_enable,
    output wire logic                irq
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic rose(input logic prev, input logic cur);
        rose = cur & ~prev;
    endfunction

    sctx_pkg::sctx_state_s s_q;
    sctx_pkg::sctx_state_s s_d;

    logic [1:0]               mode_w;
    logic                     gauss_w;
    logic [15:0]              half_w;
    logic [3:0]               div_w;
    logic                     xoeb_w;
    logic [2:0]               msel_w;
    logic                     req_w;
    logic                     ref_tick_w;
    logic [sctx_pkg::EV_W-1:0] ev_w;
    logic [sctx_pkg::EV_W-1:0] clr_w;

    assign mode_w  = s_q.latch[sctx_pkg::LAT_MOD][sctx_pkg::MODE_HI:sctx_pkg::MODE_LO];
    assign gauss_w = (mode_w == sctx_pkg::MODE_GFSK) || (mode_w == sctx_pkg::MODE_GOOK);
    assign half_w  = s_q.latch[sctx_pkg::LAT_MOD][sctx_pkg::RATE_HI:sctx_pkg::RATE_LO];
    assign div_w   = s_q.latch[sctx_pkg::LAT_REF][sctx_pkg::CLKDIV_HI:sctx_pkg::CLKDIV_LO];
    assign xoeb_w  = s_q.latch[sctx_pkg::LAT_REF][sctx_pkg::XOEB_BIT];
    assign msel_w  = s_q.latch[sctx_pkg::LAT_MUX][sctx_pkg::MUXSEL_HI:sctx_pkg::MUXSEL_LO];
    assign req_w   = wb_cyc_i && wb_stb_i && !s_q.ack;
    // internal oscillator is modelled as one tick per system clock
    assign ref_tick_w = xoeb_w ? rose(s_q.osc_p, ref_oscillator_pin_two) : 1'b1; // [RULE11]

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d    = s_q;
        ev_w   = '0;
        clr_w  = '0;
        s_d.sclk_p = serial_clk;
        s_d.le_p   = latch_load_strobe;
        s_d.osc_p  = ref_oscillator_pin_two;
        s_d.lock_p = status_in.pll_lock;

        // serial word entry; older bits fall off the top
        if (rose(s_q.sclk_p, serial_clk)) begin
            s_d.shift = {s_q.shift[sctx_pkg::WORD_W-2:0], serial_data}; // [RULE1] [RULE13]
            if (s_q.nbits == sctx_pkg::NBITS_FULL) begin
                ev_w[sctx_pkg::EV_OVERRUN] = 1'b1; // [RULE13]
            end else begin
                s_d.nbits = s_q.nbits + 6'h01;
            end
        end
        // a load in the same cycle as a clock edge takes the word before that edge
        if (rose(s_q.le_p, latch_load_strobe)) begin
            s_d.latch[s_q.shift[1:0]] = s_q.shift; // [RULE3] [RULE2]
            s_d.nbits = '0;
            ev_w[sctx_pkg::EV_LOAD] = 1'b1;
        end

        // tx bit clock: host moves data on the fall, we sample on the rise
        case (s_q.txc)
            sctx_pkg::TXC_IDLE: begin
                s_d.tx_clk  = 1'b0;
                s_d.txc_cnt = '0;
                s_d.tx_bit  = tx_bit_input; // [RULE7]
                if (gauss_w) begin
                    s_d.txc = sctx_pkg::TXC_LOW; // [RULE4]
                end
            end
            sctx_pkg::TXC_LOW: begin
                s_d.txc_cnt = s_q.txc_cnt + 16'h0001;
                if (!gauss_w) begin
                    s_d.txc = sctx_pkg::TXC_IDLE;
                end else if (s_q.txc_cnt + 16'h0001 >= half_w) begin
                    s_d.txc     = sctx_pkg::TXC_HIGH;
                    s_d.txc_cnt = '0;
                    s_d.tx_clk  = 1'b1;
                    s_d.tx_bit  = tx_bit_input; // [RULE6] [RULE5]
                    ev_w[sctx_pkg::EV_TXBIT] = 1'b1;
                end
            end
            sctx_pkg::TXC_HIGH: begin
                s_d.txc_cnt = s_q.txc_cnt + 16'h0001;
                if (!gauss_w) begin
                    s_d.txc    = sctx_pkg::TXC_IDLE;
                    s_d.tx_clk = 1'b0;
                end else if (s_q.txc_cnt + 16'h0001 >= half_w) begin
                    s_d.txc     = sctx_pkg::TXC_LOW;
                    s_d.txc_cnt = '0;
                    s_d.tx_clk  = 1'b0; // [RULE4]
                end
            end
            default: begin
                s_d.txc    = sctx_pkg::TXC_IDLE;
                s_d.tx_clk = 1'b0;
            end
        endcase
        if (!gauss_w) begin
            s_d.tx_clk = 1'b0; // [RULE4]
        end

        // clock out toggles every div+1 reference ticks, so high equals low
        if (ref_tick_w) begin
            if (s_q.ref_cnt >= div_w) begin
                s_d.ref_cnt = '0;
                s_d.clk_out = ~s_q.clk_out; // [RULE8]
            end else begin
                s_d.ref_cnt = s_q.ref_cnt + 4'h1;
            end
        end

        case (msel_w)
            sctx_pkg::MUX_REG_READY: s_d.mux_out = status_in.reg_ready; // [RULE10]
            sctx_pkg::MUX_LOCK:      s_d.mux_out = status_in.pll_lock;  // [RULE9]
            sctx_pkg::MUX_BATT_LOW:  s_d.mux_out = status_in.batt_low;  // [RULE9]
            sctx_pkg::MUX_HIGH:      s_d.mux_out = 1'b1;
            default:                 s_d.mux_out = 1'b0;
        endcase

        if (s_q.lock_p && !status_in.pll_lock) begin
            ev_w[sctx_pkg::EV_UNLOCK] = 1'b1;
        end

        // powered down: configuration and pin state are lost
        if (!chip_enable) begin
            s_d.shift   = '0; // [RULE12]
            s_d.nbits   = '0;
            s_d.latch   = '0; // [RULE12]
            s_d.txc     = sctx_pkg::TXC_IDLE;
            s_d.txc_cnt = '0;
            s_d.tx_clk  = 1'b0;
            s_d.tx_bit  = 1'b0;
            s_d.ref_cnt = '0;
            s_d.clk_out = 1'b0;
            s_d.mux_out = 1'b0;
            ev_w        = '0;
        end

        // ------------------------------------------------------------------
        // wishbone slave, one wait state, unmapped reads return zero
        // ------------------------------------------------------------------
        s_d.ack = req_w;
        if (req_w && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == sctx_pkg::ADR_STATUS) begin
                clr_w = wb_dat_i[sctx_pkg::EV_W-1:0];
            end
            if (wb_adr_i == sctx_pkg::ADR_MASK) begin
                s_d.mask = wb_dat_i[sctx_pkg::EV_W-1:0];
            end
        end
        // a new event beats a clear in the same cycle
        s_d.stat = (s_q.stat & ~clr_w) | ev_w;
        if (req_w) begin
            case (wb_adr_i)
                sctx_pkg::ADR_LATCH0: s_d.rdat = s_q.latch[0];
                sctx_pkg::ADR_LATCH1: s_d.rdat = s_q.latch[1];
                sctx_pkg::ADR_LATCH2: s_d.rdat = s_q.latch[2];
                sctx_pkg::ADR_LATCH3: s_d.rdat = s_q.latch[3];
                sctx_pkg::ADR_STATUS: s_d.rdat = {28'h0000000, s_q.stat};
                sctx_pkg::ADR_MASK:   s_d.rdat = {28'h0000000, s_q.mask};
                sctx_pkg::ADR_SHIFT:  s_d.rdat = s_q.shift;
                sctx_pkg::ADR_LIVE:   s_d.rdat = {20'h00000, s_q.nbits, s_q.txc, s_q.tx_clk,
                                                  s_q.clk_out, s_q.mux_out};
                default:              s_d.rdat = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q     <= '0;
            s_q.txc <= sctx_pkg::TXC_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o              = s_q.rdat;
    assign wb_ack_o              = s_q.ack;
    assign tx_bit_clock          = s_q.tx_clk;
    assign modulated_bit         = s_q.tx_bit;
    assign status_mux_output     = s_q.mux_out;
    assign divided_ref_clock_out = s_q.clk_out;
    assign xtal_osc_enable       = chip_enable && !xoeb_w; // [RULE11]
    assign irq                   = |(s_q.stat & s_q.mask);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_shift_entry: assert property (@(posedge sys_clk) disable iff (reset) // [RULE1]
        (chip_enable && !s_q.sclk_p && serial_clk)
        |=> (s_q.shift == {$past(s_q.shift[30:0]), $past(serial_data)}))
        else $error("shift register missed a serial clock edge");

    chk_latch_load: assert property (@(posedge sys_clk) disable iff (reset) // [RULE3]
        (chip_enable && !s_q.le_p && latch_load_strobe)
        |=> (s_q.latch[$past(s_q.shift[1:0])] == $past(s_q.shift)))
        else $error("load strobe did not fill the selected latch");

    chk_tx_bit_clock_quiet: assert property (@(posedge sys_clk) disable iff (reset) // [RULE4]
        !gauss_w |=> !s_q.tx_clk)
        else $error("tx bit clock runs outside gaussian modes");

    // leaving a gaussian mode may cut a half period short, which is allowed
    chk_tx_bit_clock_halfbit: assert property (@(posedge sys_clk) disable iff (reset || !gauss_w) // [RULE4]
        (gauss_w && $rose(s_q.tx_clk) && half_w == 16'h0003 && $stable(half_w))
        |-> s_q.tx_clk [*3] ##1 !s_q.tx_clk)
        else $error("tx bit clock half period wrong");

    chk_tx_sample: assert property (@(posedge sys_clk) disable iff (reset) // [RULE6]
        $rose(s_q.tx_clk) |-> (s_q.tx_bit == $past(tx_bit_input)))
        else $error("tx data not sampled on rising bit clock");

    chk_divided_ref_clock_out_even: assert property (@(posedge sys_clk) disable iff (reset) // [RULE8]
        ($changed(s_q.clk_out) && $past(chip_enable))
        |-> ($past(s_q.ref_cnt) >= $past(div_w)))
        else $error("clock out toggled before its count");

    chk_mux_lock: assert property (@(posedge sys_clk) disable iff (reset) // [RULE9]
        (chip_enable && msel_w == sctx_pkg::MUX_LOCK) |=> (s_q.mux_out == $past(status_in.pll_lock)))
        else $error("status mux does not follow lock");

    chk_mux_ready: assert property (@(posedge sys_clk) disable iff (reset) // [RULE10]
        (chip_enable && msel_w == sctx_pkg::MUX_REG_READY)
        |=> (s_q.mux_out == $past(status_in.reg_ready)))
        else $error("status mux does not follow regulator ready");

    chk_ext_ref: assert property (@(posedge sys_clk) disable iff (reset) // [RULE11]
        (chip_enable && xoeb_w && !(!s_q.osc_p && ref_oscillator_pin_two)) |=> $stable(s_q.ref_cnt))
        else $error("reference divider moved without an external edge");

    chk_ce_clear: assert property (@(posedge sys_clk) disable iff (reset) // [RULE12]
        !chip_enable |=> (s_q.latch == '0 && s_q.shift == '0 && !s_q.tx_clk))
        else $error("power down left configuration behind");

    chk_overrun_flag: assert property (@(posedge sys_clk) disable iff (reset) // [RULE13]
        (chip_enable && !s_q.sclk_p && serial_clk && s_q.nbits == sctx_pkg::NBITS_FULL)
        |=> s_q.stat[sctx_pkg::EV_OVERRUN])
        else $error("overrun not flagged");

endmodule // sctx_port

// ===== test/sctx_host_model.sv
// host microcontroller model: serial configuration port and tx data
`timescale 1ns/100ps

module sctx_host_model (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic tx_bit_clock,
    output logic      serial_clk,
    output logic      serial_data,
    output logic      latch_load_strobe,
    output logic      tx_bit_input
);
    logic       txc_q;
    logic [7:0] pat_q;

    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_load_strobe = 1'b0;
    end

    // every pin level is held at least two cycles so the sampled edge detect sees it
    task automatic send_bit(input logic b);
        @(posedge sys_clk);
        serial_data <= b;
        @(posedge sys_clk);
        serial_clk <= 1'b1;
        repeat (2) @(posedge sys_clk);
        serial_clk <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic load();
        @(posedge sys_clk);
        latch_load_strobe <= 1'b1;
        repeat (2) @(posedge sys_clk);
        latch_load_strobe <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            send_bit(w[i]);
        end
        load();
    endtask

    // next data bit goes out only once the bit clock has been seen falling
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            txc_q <= 1'b0;
            pat_q <= 8'hB4;
            tx_bit_input <= 1'b0;
        end else begin
            txc_q <= tx_bit_clock;
            if (txc_q && !tx_bit_clock) begin
                tx_bit_input <= pat_q[7];
                pat_q <= {pat_q[6:0], pat_q[7]};
            end
        end
    end
endmodule // sctx_host_model

// ===== test/serial_config_and_tx_data_port_tb_top.sv
// self-checking testbench of the serial config and tx data port
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module serial_config_and_tx_data_port_tb_top;
    logic                 sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, chip_enable;
    logic [3:0]           wb_sel_i;
    logic [7:0]           wb_adr_i;
    logic [31:0]          wb_dat_i, wb_dat_o, rd;
    logic                 wb_ack_o, serial_clk, serial_data, latch_load_strobe, tx_bit_input;
    sctx_pkg::sctx_stat_s status_in;
    logic                 tx_bit_clock, modulated_bit, status_mux_output, divided_ref_clock_out;
    logic                 xtal_osc_enable, irq, ref_osc;
    int                   err_total, num_checks, hi, lo, n;

    sctx_port i_sctx_port (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .chip_enable(chip_enable), .serial_clk(serial_clk), .serial_data(serial_data),
        .latch_load_strobe(latch_load_strobe), .tx_bit_input(tx_bit_input), .ref_oscillator_pin_two(ref_osc),
        .status_in(status_in), .tx_bit_clock(tx_bit_clock), .modulated_bit(modulated_bit),
        .status_mux_output(status_mux_output), .divided_ref_clock_out(divided_ref_clock_out),
        .xtal_osc_enable(xtal_osc_enable), .irq(irq));
    sctx_host_model i_sctx_host_model (.sys_clk(sys_clk), .reset(reset), .tx_bit_clock(tx_bit_clock),
        .serial_clk(serial_clk), .serial_data(serial_data), .latch_load_strobe(latch_load_strobe),
        .tx_bit_input(tx_bit_input));

    // ------------------------------------------------------------------
    // bus and timing helpers
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic hang(input string what);
        $display("[ERR] %s expected done seen timeout", what);
        err_total++;
        give_verdict();
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin @(posedge sys_clk); k++; end while (wb_ack_o !== 1'b1 && k < 50);
        rd = wb_dat_o;
        if (k >= 50) hang("bus ack");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0);
        `CHK(nm, exp, rd)
    endtask

    // s selects the clock out (1) or the tx bit clock (0)
    task automatic wait_for(input bit s, input logic v, output int c);
        c = 0;
        while ((s ? divided_ref_clock_out : tx_bit_clock) !== v && c < 300) begin @(posedge sys_clk); c++; end
        if (c >= 300) hang("clock edge");
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_map();
        for (int i = 0; i < 4; i++) rd_chk("latch after reset", 8'(4 * i), 32'h0);
        rd_chk("status after reset", sctx_pkg::ADR_STATUS, 32'h0);
        wb_xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd_chk("unmapped read", 8'h20, 32'h0);
        `CHK("irq after reset", 1'b0, irq)
    endtask

    task automatic t_load_all();
        for (int i = 0; i < 4; i++) begin
            i_sctx_host_model.send_word(32'hC3A5_0F00 | 32'(i));
            rd_chk("latch word", 8'(4 * i), 32'hC3A5_0F00 | 32'(i));
        end
        rd_chk("load event", sctx_pkg::ADR_STATUS, 32'h1);
    endtask

    task automatic t_overrun();
        wb_xfer(1'b1, sctx_pkg::ADR_STATUS, 32'hF);
        i_sctx_host_model.send_bit(1'b1);
        i_sctx_host_model.send_bit(1'b0);
        i_sctx_host_model.send_word(32'h9876_5431);
        rd_chk("newest 32 bits", sctx_pkg::ADR_LATCH1, 32'h9876_5431);
        rd_chk("shift reg", sctx_pkg::ADR_SHIFT, 32'h9876_5431);
        rd_chk("overrun event", sctx_pkg::ADR_STATUS, 32'h3);
    endtask

    task automatic t_irq();
        wb_xfer(1'b1, sctx_pkg::ADR_MASK, 32'h1);
        `CHK("irq unmasked", 1'b1, irq)
        wb_xfer(1'b1, sctx_pkg::ADR_STATUS, 32'h3);
        `CHK("irq cleared", 1'b0, irq)
        wb_xfer(1'b1, sctx_pkg::ADR_MASK, 32'h0);
        i_sctx_host_model.send_word(32'h0000_0F01);
        `CHK("irq masked", 1'b0, irq)
        rd_chk("masked event", sctx_pkg::ADR_STATUS, 32'h1);
        wb_xfer(1'b1, sctx_pkg::ADR_STATUS, 32'hF);
    endtask

    task automatic t_mux();
        logic e;
        for (int v = 0; v < 2; v++) begin
            status_in <= v ? 3'h5 : 3'h2;
            for (int s = 0; s < 4; s++) begin
                i_sctx_host_model.send_word(32'(s << 4) | 32'h3);
                e = (s == 3) ? 1'b1 : (s == 0) ? status_in[0] : (s == 1) ? status_in[2] : status_in[1];
                `CHK("status mux", e, status_mux_output)
            end
        end
        // lock falling away must leave its event beside the load events
        status_in <= 3'h0;
        repeat (3) @(posedge sys_clk);
        rd_chk("lock lost event", sctx_pkg::ADR_STATUS, 32'h5);
        wb_xfer(1'b1, sctx_pkg::ADR_STATUS, 32'hF);
    endtask

    task automatic t_divided_ref_clock_out();
        logic lvl;
        i_sctx_host_model.send_word(32'h0000_0100);
        wait_for(1'b1, 1'b1, n);
        wait_for(1'b1, 1'b0, hi);
        wait_for(1'b1, 1'b1, lo);
        `CHK("clk out high", 2, hi)
        `CHK("clk out low", 2, lo)
        `CHK("xtal on", 1'b1, xtal_osc_enable)
        i_sctx_host_model.send_word(32'h0000_1100);
        `CHK("xtal off", 1'b0, xtal_osc_enable)
        // external reference idle: the divider must not move on its own
        lvl = divided_ref_clock_out;
        repeat (20) @(posedge sys_clk);
        `CHK("clk out held", lvl, divided_ref_clock_out)
        // two external rising edges make one half period with a divider of 1
        repeat (2) begin
            ref_osc <= 1'b1;
            repeat (2) @(posedge sys_clk);
            ref_osc <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
        `CHK("clk out ext ref", ~lvl, divided_ref_clock_out)
        i_sctx_host_model.send_word(32'h0000_0100);
    endtask

    task automatic t_tx_bit_clock();
        for (int m = 0; m < 4; m++) begin
            i_sctx_host_model.send_word(32'h0000_00C2 | 32'(m << 4));
            if (m[0]) begin
                for (int b = 0; b < 3; b++) begin
                    wait_for(1'b0, 1'b1, n);
                    `CHK("sampled bit", tx_bit_input, modulated_bit)
                    wait_for(1'b0, 1'b0, hi);
                    wait_for(1'b0, 1'b1, lo);
                    `CHK("tx clk high", 3, hi)
                    `CHK("tx clk low", 3, lo)
                end
            end else begin
                repeat (8) @(posedge sys_clk);
                n = 0;
                repeat (30) @(posedge sys_clk) n += (tx_bit_clock !== 1'b0);
                `CHK("tx clk idle", 0, n)
            end
        end
    endtask

    task automatic t_power_down();
        @(posedge sys_clk);
        chip_enable <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chip_enable <= 1'b1;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 4; i++) rd_chk("latch cleared", 8'(4 * i), 32'h0);
        i_sctx_host_model.send_word(32'h0000_0F00);
        rd_chk("latch rewritten", sctx_pkg::ADR_LATCH0, 32'h0000_0F00);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        hang("whole run");
    end

    initial begin
        {reset, chip_enable, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
        {wb_sel_i, wb_adr_i, wb_dat_i} = '0;
        status_in = 3'h0;
        ref_osc = 1'b0;
        {err_total, num_checks} = '0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_map();
        t_load_all();
        t_overrun();
        t_irq();
        t_mux();
        t_divided_ref_clock_out();
        t_tx_bit_clock();
        t_power_down();
        give_verdict();
    end
endmodule // serial_config_and_tx_data_port_tb_top
